// ### hw/rclc_pkg.sv
// Purpose: Shared constants of the reset cause and lockup control block
// Assumes: 32-bit APB, byte addresses, pclk at 125 MHz
// Notes: Interrupt registers use the cause bit layout of the status word
package rclc_pkg;

  // Register byte addresses
  localparam logic [31:0] RCLC_STATUS_ADDR = 32'h4000_000C;
  localparam logic [31:0] RCLC_IRQ_STAT_ADDR = 32'h4000_0010;
  localparam logic [31:0] RCLC_IRQ_MASK_ADDR = 32'h4000_0014;

  // Field positions
  localparam int RCLC_PIN_BIT = 0;
  localparam int RCLC_SWREQ_BIT = 1;
  localparam int RCLC_HANG_BIT = 2;
  localparam int RCLC_DEBUG_BIT = 3;
  localparam int RCLC_ALLOWED_BIT = 7;
  localparam int RCLC_HANG_KEY_LSB = 0;
  localparam int RCLC_DEBUG_KEY_LSB = 16;
  localparam int RCLC_CAUSES = 4;

  // Keys
  localparam logic [7:0] RCLC_HANG_KEY = 8'hC9;
  localparam logic [7:0] RCLC_DEBUG_KEY = 8'h3A;

  // Reset values
  localparam logic [3:0] RCLC_FLAGS_RST = 4'h1;
  localparam logic [3:0] RCLC_IRQ_RST = 4'h0;
  localparam logic [7:0] RCLC_DEBUG_FIELD_RST = 8'h00;
  localparam logic [31:0] RCLC_ZERO_WORD = 32'h0000_0000;

  // Timing
  localparam int RCLC_CLK_PERIOD_NS = 8;
  localparam int RCLC_RST_PULSE_NS = 128;
  localparam int RCLC_RST_PULSE_CYCLES =
    (RCLC_RST_PULSE_NS + RCLC_CLK_PERIOD_NS - 1) / RCLC_CLK_PERIOD_NS;

  // Reset sequencer states
  typedef enum logic {
    RCLC_SEQ_RUN,
    RCLC_SEQ_HOLD
  } rclc_seq_t;

endpackage

// ### hw/rclc_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Input is asynchronous to pclk
// Notes: Only the second stage may be read by other logic
module rclc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ### hw/rclc_top.sv
// Purpose: Reset cause recording, lockup reset enable and debug reset
// Assumes: Core and debug port logic run on pclk; reset pin is async
// Notes: presetn is the power-on reset of this block only
module rclc_top
  import rclc_pkg::*;
#(
  parameter int RST_CYCLES = RCLC_RST_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources
  input wire logic ext_reset_pin_n,
  input wire logic soft_reset_req,
  input wire logic core_lockup,
  // Debug port write path
  input wire logic dbg_wr,
  input wire logic [31:0] dbg_wdata,
  // System reset and interrupt
  output logic sys_reset,
  output logic irq
);

  localparam int CW = $clog2(RST_CYCLES + 1);

  // State
  logic pin_reset_flag;
  logic software_reset_request_flag;
  logic core_hang_reset_flag;
  logic debug_reset_flag;
  logic hang_reset_allowed;
  logic [7:0] debug_reset_key_field;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic pin_sync_n;
  logic pin_prev;
  rclc_seq_t seq_state;
  logic [CW-1:0] hold_cnt;

  // Combinational nets
  wire logic [3:0] flags;
  wire logic [3:0] cause_evt;
  wire logic any_evt;
  wire logic pin_event;
  wire logic hang_event;
  wire logic debug_event;
  wire logic acc_first;
  wire logic done;
  wire logic sel_status;
  wire logic sel_istat;
  wire logic sel_imask;
  wire logic mapped;
  wire logic rd_clr;
  wire logic wr_status;
  wire logic wr_istat;
  wire logic wr_imask;
  wire logic [31:0] status_word;
  wire logic [31:0] rd_mux;
  wire logic [3:0] next_flags;
  wire logic [3:0] next_irq_status;
  wire logic [3:0] next_irq_mask;
  wire logic next_allowed;
  wire logic [7:0] next_debug_field;
  rclc_seq_t next_seq_state;
  logic [CW-1:0] next_hold_cnt;

  function automatic logic key_match(input logic [31:0] word,
                                     input int lsb,
                                     input logic [7:0] key);
    key_match = (word[lsb +: 8] == key);
  endfunction

  // Pin synchroniser
  rclc_sync #(
    .WIDTH(1),
    .RST_VAL(1'b1)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(ext_reset_pin_n),
    .sync_out(pin_sync_n)
  );

  // Cause detection
  assign pin_event = !pin_sync_n && pin_prev;
  assign hang_event = core_lockup && hang_reset_allowed;
  assign debug_event = dbg_wr &&
    key_match(dbg_wdata, RCLC_DEBUG_KEY_LSB, RCLC_DEBUG_KEY);
  assign cause_evt = {debug_event, hang_event, soft_reset_req, pin_event};
  assign any_evt = |cause_evt;

  // APB decode
  assign acc_first = psel && penable && !pready;
  assign done = psel && penable && pready;
  assign sel_status = (paddr == RCLC_STATUS_ADDR);
  assign sel_istat = (paddr == RCLC_IRQ_STAT_ADDR);
  assign sel_imask = (paddr == RCLC_IRQ_MASK_ADDR);
  assign mapped = sel_status || sel_istat || sel_imask;
  assign rd_clr = done && !pwrite && sel_status;
  assign wr_status = done && pwrite && sel_status;
  assign wr_istat = done && pwrite && sel_istat;
  assign wr_imask = done && pwrite && sel_imask;

  // Read data
  assign flags = {debug_reset_flag, core_hang_reset_flag,
                  software_reset_request_flag, pin_reset_flag};
  assign status_word = {8'h00, debug_reset_key_field, 8'h00,
                        hang_reset_allowed, 3'h0, flags};
  assign rd_mux = sel_status ? status_word :
                  sel_istat ? {28'h000_0000, irq_status} :
                  sel_imask ? {28'h000_0000, irq_mask} : RCLC_ZERO_WORD;

  assign next_flags = (flags & ~{RCLC_CAUSES{rd_clr}}) | cause_evt;

  // Interrupt status and mask
  assign next_irq_status =
    (irq_status & ~(wr_istat ? pwdata[3:0] : 4'h0)) | cause_evt;
  assign next_irq_mask = wr_imask ? pwdata[3:0] : irq_mask;

  assign next_allowed = any_evt ? 1'b0 :
    wr_status ? key_match(pwdata, RCLC_HANG_KEY_LSB, RCLC_HANG_KEY) :
    dbg_wr ? key_match(dbg_wdata, RCLC_HANG_KEY_LSB, RCLC_HANG_KEY) :
    hang_reset_allowed;

  // only the debug port writes it
  assign next_debug_field = dbg_wr ? dbg_wdata[RCLC_DEBUG_KEY_LSB +: 8] :
                            debug_reset_key_field;

  // Reset pulse sequencer
  always_comb begin
    next_seq_state = seq_state;
    next_hold_cnt = hold_cnt;
    case (seq_state)
      RCLC_SEQ_RUN: begin
        if (any_evt) begin
          next_seq_state = RCLC_SEQ_HOLD;
          next_hold_cnt = CW'(RST_CYCLES - 1);
        end
      end
      RCLC_SEQ_HOLD: begin
        if (any_evt) begin
          next_hold_cnt = CW'(RST_CYCLES - 1);
        end else if (hold_cnt == '0) begin
          next_seq_state = RCLC_SEQ_RUN;
        end else begin
          next_hold_cnt = hold_cnt - 1'b1;
        end
      end
      default: begin
        next_seq_state = RCLC_SEQ_RUN;
        next_hold_cnt = '0;
      end
    endcase
  end

  // APB answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RCLC_ZERO_WORD;
    end else begin
      pready <= acc_first;
      if (acc_first) begin
        pslverr <= !mapped;
        prdata <= pwrite ? RCLC_ZERO_WORD : rd_mux;
      end else begin
        pslverr <= 1'b0;
        prdata <= RCLC_ZERO_WORD;
      end
    end
  end

  // Cause flags and control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {debug_reset_flag, core_hang_reset_flag,
       software_reset_request_flag, pin_reset_flag} <= RCLC_FLAGS_RST;
      hang_reset_allowed <= 1'b0;
      debug_reset_key_field <= RCLC_DEBUG_FIELD_RST;
      pin_prev <= 1'b1;
    end else begin
      {debug_reset_flag, core_hang_reset_flag,
       software_reset_request_flag, pin_reset_flag} <= next_flags;
      hang_reset_allowed <= next_allowed;
      debug_reset_key_field <= next_debug_field;
      pin_prev <= pin_sync_n;
    end
  end

  // Interrupt registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= RCLC_IRQ_RST;
      irq_mask <= RCLC_IRQ_RST;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      irq <= |(next_irq_status & next_irq_mask);
    end
  end

  // Sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_state <= RCLC_SEQ_RUN;
      hold_cnt <= '0;
      sys_reset <= 1'b0;
    end else begin
      seq_state <= next_seq_state;
      hold_cnt <= next_hold_cnt;
      sys_reset <= (next_seq_state == RCLC_SEQ_HOLD);
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_status_read;
    done && !pwrite && sel_status;
  endsequence

  sequence s_core_status_write;
    wr_status && !dbg_wr;
  endsequence

  sequence s_reset_held;
    sys_reset && hold_cnt == CW'(RST_CYCLES - 1);
  endsequence

  property p_pin_flag;
    pin_event |=> pin_reset_flag && sys_reset;
  endproperty
  a_pin_flag: assert property (p_pin_flag)
    else $error("pin reset not recorded");

  property p_sw_flag;
    soft_reset_req |=> software_reset_request_flag && sys_reset;
  endproperty
  a_sw_flag: assert property (p_sw_flag)
    else $error("software reset request not recorded");

  property p_hang_flag;
    core_lockup && hang_reset_allowed |=> core_hang_reset_flag;
  endproperty
  a_hang_flag: assert property (p_hang_flag)
    else $error("lockup reset not recorded");

  property p_read_clears;
    s_status_read and (cause_evt == 4'h0) |=> flags == 4'h0;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status read did not clear flags");

  property p_reserved_zero;
    s_status_read |-> prdata[6:4] == 3'h0 && prdata[15:8] == 8'h00 &&
                      prdata[31:24] == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("unused status bits not zero");

  property p_allowed_read;
    s_status_read |-> prdata[RCLC_ALLOWED_BIT] == $past(hang_reset_allowed);
  endproperty
  a_allowed_read: assert property (p_allowed_read)
    else $error("bit 7 does not show lockup allowance");

  property p_key_write;
    s_core_status_write and (cause_evt == 4'h0) |=>
      hang_reset_allowed == ($past(pwdata[7:0]) == RCLC_HANG_KEY);
  endproperty
  a_key_write: assert property (p_key_write)
    else $error("lockup allowance key not honoured");

  property p_any_reset_forbids;
    any_evt |=> !hang_reset_allowed;
  endproperty
  a_any_reset_forbids: assert property (p_any_reset_forbids)
    else $error("reset did not forbid lockup reset");

  property p_debug_reset;
    debug_event |=> debug_reset_flag ##0 s_reset_held;
  endproperty
  a_debug_reset: assert property (p_debug_reset)
    else $error("debug request did not hold system reset");

  property p_core_no_debug;
    s_core_status_write |=>
      debug_reset_key_field == $past(debug_reset_key_field);
  endproperty
  a_core_no_debug: assert property (p_core_no_debug)
    else $error("core write changed debug key field");

  property p_hang_ignored;
    core_lockup && !hang_reset_allowed && cause_evt == 4'h0 &&
      seq_state == RCLC_SEQ_RUN && !rd_clr |=>
      !sys_reset && core_hang_reset_flag == $past(core_hang_reset_flag);
  endproperty
  a_hang_ignored: assert property (p_hang_ignored)
    else $error("forbidden lockup had an effect");

  property p_hold_count;
    seq_state == RCLC_SEQ_HOLD && hold_cnt != '0 && !any_evt |=>
      sys_reset && hold_cnt == $past(hold_cnt) - 1'b1;
  endproperty
  a_hold_count: assert property (p_hold_count)
    else $error("reset pulse count broken");

  property p_hold_release;
    seq_state == RCLC_SEQ_HOLD && hold_cnt == '0 && !any_evt |=> !sys_reset;
  endproperty
  a_hold_release: assert property (p_hold_release)
    else $error("reset pulse did not end");

endmodule

// ### testbench/rclc_host_model.sv
// Purpose: Core and debug port stand-in driving the reset sources
// Assumes: Every change lands just after a rising pclk edge
// Notes: Debug data shows inverted junk outside its strobe
module rclc_host_model (
  // Clock
  input wire logic pclk,
  // Reset sources
  output logic ext_reset_pin_n,
  output logic soft_reset_req,
  output logic core_lockup,
  // Debug port
  output logic dbg_wr,
  output logic [31:0] dbg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    ext_reset_pin_n = 1'b1;
    soft_reset_req = 1'b0;
    core_lockup = 1'b0;
    dbg_wr = 1'b0;
    dbg_wdata = 32'h5A5A_5A5A;
  end

  task sw_req();
    @(posedge pclk);
    soft_reset_req <= 1'b1;
    @(posedge pclk);
    soft_reset_req <= 1'b0;
  endtask

  task hang(input logic on);
    @(posedge pclk);
    core_lockup <= on;
  endtask

  task dbg(input logic [31:0] d);
    @(posedge pclk);
    dbg_wr <= 1'b1;
    dbg_wdata <= d;
    @(posedge pclk);
    dbg_wr <= 1'b0;
    dbg_wdata <= ~d;
  endtask

  task pin_pulse();
    @(posedge pclk);
    ext_reset_pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    ext_reset_pin_n <= 1'b1;
  endtask
endmodule

// ### testbench/rclc_top_tb.sv
// Purpose: Self-checking bench of the reset cause block over APB
// Assumes: Short reset pulse of 2 cycles
// Notes: Core and debug port come from the host model
module rclc_top_tb
  import rclc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HOLD_CYC = 2;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, dbg_wdata;
  logic ext_reset_pin_n, soft_reset_req, core_lockup, dbg_wr;
  logic sys_reset, irq;
  int mismatches, comparisons, hits;

  rclc_top #(.RST_CYCLES(HOLD_CYC)) u_rclc_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_reset_pin_n(ext_reset_pin_n),
    .soft_reset_req(soft_reset_req), .core_lockup(core_lockup),
    .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata), .sys_reset(sys_reset),
    .irq(irq)
  );

  rclc_host_model u_rclc_host_model (
    .pclk(pclk), .ext_reset_pin_n(ext_reset_pin_n),
    .soft_reset_req(soft_reset_req), .core_lockup(core_lockup),
    .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata)
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask

  task apb(input logic is_wr, input logic [31:0] a, input logic [31:0] d,
           output logic [31:0] rdat, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
    chk("write error", 32'h0, {31'h0, er});
  endtask

  task rd(input logic [31:0] a, input logic [31:0] exp, input logic eer,
          input string nm);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    chk(nm, exp, r);
    chk({nm, " error"}, {31'h0, eer}, {31'h0, er});
  endtask

  task wait_rst(input string nm);
    int n;
    n = 0;
    while (sys_reset !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk({nm, " reset rise"}, 32'h1, {31'h0, sys_reset});
    n = 0;
    while (sys_reset !== 1'b0 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk({nm, " reset fall"}, 32'h0, {31'h0, sys_reset});
    chk({nm, " reset length"}, 32'(HOLD_CYC), 32'(n));
  endtask

  task irq_is(input logic v, input string nm);
    repeat (2) @(posedge pclk);
    chk(nm, {31'h0, v}, {31'h0, irq});
  endtask

  task final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge pclk);
    mismatches++;
    final_report();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    mismatches = 0;
    comparisons = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(RCLC_STATUS_ADDR, 32'h1, 1'b0, "status after reset");
    rd(RCLC_STATUS_ADDR, 32'h0, 1'b0, "status cleared");
    rd(32'h4000_0018, 32'h0, 1'b1, "unmapped");
    wr(RCLC_STATUS_ADDR, {24'h0, RCLC_HANG_KEY});
    rd(RCLC_STATUS_ADDR, 32'h80, 1'b0, "allowed");
    wr(RCLC_STATUS_ADDR, 32'h3A00_00C8);
    rd(RCLC_STATUS_ADDR, 32'h0, 1'b0, "forbidden");
    $display("test keys done");
    wr(RCLC_IRQ_MASK_ADDR, 32'h2);
    u_rclc_host_model.sw_req();
    wait_rst("request");
    irq_is(1'b1, "irq raised");
    rd(RCLC_IRQ_STAT_ADDR, 32'h2, 1'b0, "irq status");
    rd(RCLC_STATUS_ADDR, 32'h2, 1'b0, "request flag");
    wr(RCLC_IRQ_STAT_ADDR, 32'hF);
    irq_is(1'b0, "irq cleared");
    $display("test request done");
    u_rclc_host_model.hang(1'b1);
    hits = 0;
    repeat (10) begin
      @(posedge pclk);
      if (sys_reset === 1'b1) hits++;
    end
    chk("hang forbidden", 32'h0, 32'(hits));
    rd(RCLC_STATUS_ADDR, 32'h0, 1'b0, "hang flag idle");
    wr(RCLC_STATUS_ADDR, {24'h0, RCLC_HANG_KEY});
    wait_rst("hang");
    u_rclc_host_model.hang(1'b0);
    irq_is(1'b0, "irq masked");
    rd(RCLC_STATUS_ADDR, 32'h4, 1'b0, "hang flag");
    $display("test hang done");
    u_rclc_host_model.dbg(32'h003A_00C9);
    wait_rst("debug");
    rd(RCLC_STATUS_ADDR, 32'h003A_0008, 1'b0, "debug flag");
    wr(RCLC_STATUS_ADDR, {24'h0, RCLC_HANG_KEY});
    u_rclc_host_model.pin_pulse();
    wait_rst("pin");
    rd(RCLC_STATUS_ADDR, 32'h003A_0001, 1'b0, "pin flag");
    $display("test sources done");
    final_report();
  end
endmodule
